/* rtl/sif_edge_det.sv */
// Per-bit falling-edge and change detector on the sampled levels
`timescale 1ns/1ps
module sif_edge_det
  import sif_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  sif_evt_if.det    ev
);

  typedef struct packed {
    logic [7:0] prev;
    logic       primed;
  } sif_det_state_t;

  sif_det_state_t st_r;
  sif_det_state_t st_nxt;

  // Capture every cycle; the first cycle after reset only primes the
  // history so a level that is already high or low raises no event
  always_comb begin
    st_nxt        = st_r;
    st_nxt.prev   = ev.level;
    st_nxt.primed = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r.prev   <= SIF_RST_PREV;
      st_r.primed <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // One detector per level bit
  for (genvar i = 0; i < SIF_NLEVEL; i++) begin : g_bit
    assign ev.fall[i] = st_r.primed & st_r.prev[i] & ~ev.level[i];
    assign ev.chg[i]  = st_r.primed & (st_r.prev[i] ^ ev.level[i]);
  end

  assign ev.primed = st_r.primed;

endmodule : sif_edge_det

/* rtl/sif_evt_if.sv */
// Interface carrying sampled levels and their edge events between modules
`timescale 1ns/1ps
interface sif_evt_if;
  logic [7:0] level;   // Levels as seen this cycle
  logic [7:0] fall;    // Level was high last cycle, low now
  logic [7:0] chg;     // Level differs from last cycle
  logic       primed;  // Previous sample is valid

  modport det (input level, output fall, output chg, output primed);
  modport usr (output level, input fall, input chg, input primed);
endinterface : sif_evt_if

/* rtl/sif_irq_flags.sv */
// Interrupt flag byte with mask, level interrupt and Wishbone slave
//
// Functional notes
// - A falling edge on the battery sense input sets flag bit 7.
// - Any of the three supply diagnosis bits clearing sets flag bit 6.
// - Any change of the CAN fault status sets flag bit 5.
// - Any change of the LIN fault status sets flag bit 4.
// - A falling edge on the local wake-up input sets flag bit 3.
// - A watchdog restart while the watchdog is off sets flag bit 2.
// - A CAN bus wake-up event sets flag bit 1.
// - A LIN bus wake-up event sets flag bit 0.
// - Each flag reads 0 until its event occurs and 1 from then until a one is written to it.
`timescale 1ns/1ps
module sif_irq_flags
  import sif_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Event sources
  input  wire logic        sense_i,
  input  wire logic        supply1_diag_bit_i,
  input  wire logic        supply2_diag_bit_i,
  input  wire logic        supply3_diag_bit_i,
  input  wire logic        can_fault_status_i,
  input  wire logic        lin_fault_status_i,
  input  wire logic        local_wake_i,
  input  wire logic        wd_restart_i,
  input  wire logic        wd_off_i,
  input  wire logic        can_wakeup_i,
  input  wire logic        lin_wakeup_i,
  // Interrupt request
  output logic             irq_o
);

  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  mask;
    logic        ack;
    logic [31:0] rdata;
    logic        irq;
  } sif_state_t;

  sif_state_t  st_r;
  sif_state_t  st_nxt;

  sif_evt_if   ev ();

  logic        bus_req;
  logic        wr_en;
  logic [7:0]  adr_word;
  logic [7:0]  set_vec;
  logic [7:0]  clr_vec;

  // Collect the raw levels for the edge detector and level register
  assign ev.level[SIF_LV_SENSE]    = sense_i;
  assign ev.level[SIF_LV_WAKE]     = local_wake_i;
  assign ev.level[SIF_LV_CANFAULT] = can_fault_status_i;
  assign ev.level[SIF_LV_LINFAULT] = lin_fault_status_i;
  assign ev.level[SIF_LV_DIAG1]    = supply1_diag_bit_i;
  assign ev.level[SIF_LV_DIAG2]    = supply2_diag_bit_i;
  assign ev.level[SIF_LV_DIAG3]    = supply3_diag_bit_i;
  assign ev.level[SIF_LV_WDOFF]    = wd_off_i;

  sif_edge_det u_det (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ev    (ev)
  );

  // Bus decode; the low two address bits are ignored as word aligned
  // No request is taken while ack stands, so a master that keeps stb up
  // for a cycle after ack is never served twice
  assign bus_req  = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign wr_en    = bus_req & wb_we_i & wb_sel_i[0];
  assign adr_word = {wb_adr_i[7:2], 2'b00};

  // Event vector, one bit per flag
  always_comb begin
    set_vec                    = 8'h00;
    set_vec[SIF_FLAG_BATTERY]  = ev.fall[SIF_LV_SENSE];
    set_vec[SIF_FLAG_SUPPLY]   = ev.fall[SIF_LV_DIAG1]
                               | ev.fall[SIF_LV_DIAG2]
                               | ev.fall[SIF_LV_DIAG3];
    set_vec[SIF_FLAG_CANFAULT] = ev.chg[SIF_LV_CANFAULT];
    set_vec[SIF_FLAG_LINFAULT] = ev.chg[SIF_LV_LINFAULT];
    set_vec[SIF_FLAG_LOCWAKE]  = ev.fall[SIF_LV_WAKE];
    // Restarts while the watchdog runs are handled elsewhere
    set_vec[SIF_FLAG_WDRST]    = wd_restart_i & wd_off_i;
    set_vec[SIF_FLAG_CANWAKE]  = can_wakeup_i;
    set_vec[SIF_FLAG_LINWAKE]  = lin_wakeup_i;
  end

  // Write-one-to-clear mask for the flag register
  always_comb begin
    clr_vec = 8'h00;
    if (wr_en && (adr_word == SIF_OFS_FLAGS)) begin
      clr_vec = wb_dat_i[7:0];
    end
  end

  // Next state: flags, mask, bus answer and interrupt
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = 1'b0;
    // Set beats clear so an event in the clearing cycle is kept
    st_nxt.flags = (st_r.flags & ~clr_vec) | set_vec;
    if (wr_en && (adr_word == SIF_OFS_MASK)) begin
      st_nxt.mask = wb_dat_i[7:0];
    end
    if (bus_req) begin
      st_nxt.ack = 1'b1;
      // Unmapped offsets still answer, reading zero, so no master hangs
      case (adr_word)
        SIF_OFS_FLAGS: begin
          st_nxt.rdata = {24'h00_0000, st_r.flags};
        end
        SIF_OFS_MASK: begin
          st_nxt.rdata = {24'h00_0000, st_r.mask};
        end
        SIF_OFS_LEVELS: begin
          st_nxt.rdata = {24'h00_0000, ev.level};
        end
        default: begin
          st_nxt.rdata = SIF_RST_DATA;
        end
      endcase
    end
    // Built from next values so irq_o tracks the registers with no lag
    st_nxt.irq = |(st_nxt.flags & st_nxt.mask);
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r.flags <= SIF_RST_FLAGS;
      st_r.mask  <= SIF_RST_MASK;
      st_r.ack   <= 1'b0;
      st_r.rdata <= SIF_RST_DATA;
      st_r.irq   <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = st_r.rdata;
  assign wb_ack_o = st_r.ack;
  assign irq_o    = st_r.irq;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_flags_read;
    bus_req && !wb_we_i && (adr_word == SIF_OFS_FLAGS);
  endsequence

  sequence s_flags_clear;
    wr_en && (adr_word == SIF_OFS_FLAGS);
  endsequence

  sequence s_mask_write;
    wr_en && (adr_word == SIF_OFS_MASK);
  endsequence

  sequence s_mask_read;
    bus_req && !wb_we_i && (adr_word == SIF_OFS_MASK);
  endsequence

  sequence s_level_read;
    bus_req && !wb_we_i && (adr_word == SIF_OFS_LEVELS);
  endsequence

  // Any access outside the three mapped words
  sequence s_other_req;
    bus_req && (adr_word != SIF_OFS_FLAGS) && (adr_word != SIF_OFS_MASK)
    && (adr_word != SIF_OFS_LEVELS);
  endsequence

  a_batt_fall_set: assert property (
    (ev.primed && $fell(sense_i)) |=> st_r.flags[SIF_FLAG_BATTERY])
    else $error("battery flag not set after sense fall");

  a_supply_clr_set: assert property (
    (ev.primed && ($fell(supply1_diag_bit_i) || $fell(supply2_diag_bit_i)
     || $fell(supply3_diag_bit_i))) |=> st_r.flags[SIF_FLAG_SUPPLY])
    else $error("supply flag not set after diagnosis clear");

  a_can_fault_chg: assert property (
    (ev.primed && $changed(can_fault_status_i))
    |=> st_r.flags[SIF_FLAG_CANFAULT])
    else $error("CAN fault flag not set after status change");

  a_lin_fault_chg: assert property (
    (ev.primed && $changed(lin_fault_status_i))
    |=> st_r.flags[SIF_FLAG_LINFAULT])
    else $error("LIN fault flag not set after status change");

  a_wake_fall_set: assert property (
    (ev.primed && $fell(local_wake_i)) |=> st_r.flags[SIF_FLAG_LOCWAKE])
    else $error("local wake flag not set after wake fall");

  a_wd_restart_set: assert property (
    (wd_restart_i && wd_off_i) |=> st_r.flags[SIF_FLAG_WDRST])
    else $error("watchdog restart flag not set");

  a_wd_on_quiet: assert property (
    (!st_r.flags[SIF_FLAG_WDRST] && !wd_off_i)
    |=> !st_r.flags[SIF_FLAG_WDRST])
    else $error("watchdog restart flag set while watchdog on");

  a_can_wake_set: assert property (
    can_wakeup_i |=> st_r.flags[SIF_FLAG_CANWAKE])
    else $error("CAN wake flag not set");

  a_lin_wake_set: assert property (
    lin_wakeup_i |=> st_r.flags[SIF_FLAG_LINWAKE])
    else $error("LIN wake flag not set");

  a_flags_readback: assert property (
    s_flags_read |=> (wb_ack_o && (wb_dat_o[7:0] == $past(st_r.flags))
                      && (wb_dat_o[31:8] == 24'h00_0000)))
    else $error("flag read returned wrong value");

  a_flags_quiet: assert property (
    (set_vec == 8'h00) |=> ((st_r.flags & ~$past(st_r.flags)) == 8'h00))
    else $error("flag set with no event");

  a_flags_sticky: assert property (
    !(wr_en && (adr_word == SIF_OFS_FLAGS))
    |=> ((st_r.flags & $past(st_r.flags)) == $past(st_r.flags)))
    else $error("flag dropped without a clear");

  a_set_beats_clr: assert property (
    (s_flags_clear and (set_vec != 8'h00))
    |=> ((st_r.flags & $past(set_vec)) == $past(set_vec)))
    else $error("event lost in clearing cycle");

  a_irq_level_ok: assert property (
    irq_o == |(st_r.flags & st_r.mask))
    else $error("interrupt output does not match flags and mask");

  a_ack_one_cycle: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // A flag may only rise in the cycle after its own event; each of
  // these catches a crossed wire in the event vector
  a_batt_no_event: assert property (
    (!st_r.flags[SIF_FLAG_BATTERY] && !(ev.primed && $fell(sense_i)))
    |=> !st_r.flags[SIF_FLAG_BATTERY])
    else $error("battery flag set with no sense fall");

  a_supply_no_event: assert property (
    (!st_r.flags[SIF_FLAG_SUPPLY]
     && !(ev.primed && ($fell(supply1_diag_bit_i)
     || $fell(supply2_diag_bit_i) || $fell(supply3_diag_bit_i))))
    |=> !st_r.flags[SIF_FLAG_SUPPLY])
    else $error("supply flag set with no diagnosis clear");

  a_can_fault_quiet: assert property (
    (!st_r.flags[SIF_FLAG_CANFAULT]
     && !(ev.primed && $changed(can_fault_status_i)))
    |=> !st_r.flags[SIF_FLAG_CANFAULT])
    else $error("CAN fault flag set with no status change");

  a_lin_fault_quiet: assert property (
    (!st_r.flags[SIF_FLAG_LINFAULT]
     && !(ev.primed && $changed(lin_fault_status_i)))
    |=> !st_r.flags[SIF_FLAG_LINFAULT])
    else $error("LIN fault flag set with no status change");

  a_wake_no_event: assert property (
    (!st_r.flags[SIF_FLAG_LOCWAKE] && !(ev.primed && $fell(local_wake_i)))
    |=> !st_r.flags[SIF_FLAG_LOCWAKE])
    else $error("local wake flag set with no wake fall");

  a_wd_no_restart: assert property (
    (!st_r.flags[SIF_FLAG_WDRST] && !wd_restart_i)
    |=> !st_r.flags[SIF_FLAG_WDRST])
    else $error("watchdog restart flag set with no restart");

  a_can_wake_quiet: assert property (
    (!st_r.flags[SIF_FLAG_CANWAKE] && !can_wakeup_i)
    |=> !st_r.flags[SIF_FLAG_CANWAKE])
    else $error("CAN wake flag set with no wake event");

  a_lin_wake_quiet: assert property (
    (!st_r.flags[SIF_FLAG_LINWAKE] && !lin_wakeup_i)
    |=> !st_r.flags[SIF_FLAG_LINWAKE])
    else $error("LIN wake flag set with no wake event");

  // Cleared bits drop unless their event arrives in the same cycle
  a_clear_drops: assert property (
    s_flags_clear
    |=> ((st_r.flags & $past(clr_vec) & ~$past(set_vec)) == 8'h00))
    else $error("flag survived a clear with no event");

  // No edge may be reported before the history holds a real sample
  a_unprimed_quiet: assert property (
    !ev.primed |-> ((ev.fall == 8'h00) && (ev.chg == 8'h00)))
    else $error("edge reported before history primed");

  // Bus answer: one ack per accepted request, none otherwise
  a_ack_follows_req: assert property (
    bus_req |=> wb_ack_o)
    else $error("request not acknowledged next cycle");

  a_ack_needs_req: assert property (
    !bus_req |=> !wb_ack_o)
    else $error("ack with no request");

  // Read data stands between accesses so a slow master still sees it
  a_rdata_stands: assert property (
    !bus_req |=> $stable(wb_dat_o))
    else $error("read data changed with no access");

  a_mask_write_ok: assert property (
    s_mask_write |=> (st_r.mask == $past(wb_dat_i[7:0])))
    else $error("mask write not stored");

  a_mask_holds: assert property (
    !(wr_en && (adr_word == SIF_OFS_MASK)) |=> $stable(st_r.mask))
    else $error("mask changed with no write");

  a_mask_readback: assert property (
    s_mask_read |=> (wb_dat_o == {24'h00_0000, $past(st_r.mask)}))
    else $error("mask read returned wrong value");

  a_level_readback: assert property (
    s_level_read |=> (wb_dat_o == {24'h00_0000, $past(ev.level)}))
    else $error("level read returned wrong value");

  a_unmapped_zero: assert property (
    s_other_req |=> (wb_dat_o == SIF_RST_DATA))
    else $error("unmapped access returned nonzero data");

endmodule : sif_irq_flags

/* rtl/sif_pkg.sv */
// Package of offsets, bit positions and reset values for the flag block
package sif_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] SIF_OFS_FLAGS  = 8'h00;
  localparam logic [7:0] SIF_OFS_MASK   = 8'h04;
  localparam logic [7:0] SIF_OFS_LEVELS = 8'h08;

  // Flag bit positions in the flag and mask registers
  localparam int SIF_FLAG_BATTERY  = 7;
  localparam int SIF_FLAG_SUPPLY   = 6;
  localparam int SIF_FLAG_CANFAULT = 5;
  localparam int SIF_FLAG_LINFAULT = 4;
  localparam int SIF_FLAG_LOCWAKE  = 3;
  localparam int SIF_FLAG_WDRST    = 2;
  localparam int SIF_FLAG_CANWAKE  = 1;
  localparam int SIF_FLAG_LINWAKE  = 0;

  // Positions of the sampled levels in the level vector and register
  localparam int SIF_LV_SENSE    = 0;
  localparam int SIF_LV_WAKE     = 1;
  localparam int SIF_LV_CANFAULT = 2;
  localparam int SIF_LV_LINFAULT = 3;
  localparam int SIF_LV_DIAG1    = 4;
  localparam int SIF_LV_DIAG2    = 5;
  localparam int SIF_LV_DIAG3    = 6;
  localparam int SIF_LV_WDOFF    = 7;

  // Reset values
  localparam logic [7:0]  SIF_RST_FLAGS = 8'h00;
  localparam logic [7:0]  SIF_RST_MASK  = 8'h00;
  localparam logic [7:0]  SIF_RST_PREV  = 8'h00;
  localparam logic [31:0] SIF_RST_DATA  = 32'h0000_0000;

  // Widths
  localparam int SIF_NFLAGS = 8;
  localparam int SIF_NLEVEL = 8;

endpackage : sif_pkg

/* testbench/sif_host_model.sv */
// Host model: Wishbone classic master that reads and clears the flags
`timescale 1ns/1ps
module sif_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  // Bus idle from time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // One classic cycle, held until ack or for at most 50 cycles; released data is inverted so a
  // slave that samples late never sees the old value by luck
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic to);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= we;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    to = 1'b1;
    q  = 32'h0000_0000;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) begin
        to = 1'b0;
        q  = dat_i;
        break;
      end
    end
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask : xfer
endmodule : sif_host_model

/* testbench/sif_irq_flags_tb.sv */
// Self-checking bench for the interrupt flag block
`timescale 1ns/1ps
module sif_irq_flags_tb
  import sif_pkg::*;
;
  logic        clk_i, rst_i, cyc, stb, we, ack, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic sense = 1'b1, wake = 1'b1, d1 = 1'b1, d2 = 1'b1, d3 = 1'b1;
  logic can_f = 1'b0, lin_f = 1'b0, wd_rst = 1'b0, wd_off = 1'b0;
  logic can_wk = 1'b0, lin_wk = 1'b0;
  int   fail_count = 0;
  int   n_checks = 0;

  sif_irq_flags dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sense_i(sense),
    .supply1_diag_bit_i(d1), .supply2_diag_bit_i(d2),
    .supply3_diag_bit_i(d3), .can_fault_status_i(can_f),
    .lin_fault_status_i(lin_f), .local_wake_i(wake),
    .wd_restart_i(wd_rst), .wd_off_i(wd_off), .can_wakeup_i(can_wk),
    .lin_wakeup_i(lin_wk), .irq_o(irq));

  sif_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(wdat));

  // Free-running 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic fail(input string m);
    fail_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) fail($sformatf("read %h, want %h", got, exp));
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) fail($sformatf("irq %b, want %b", got, exp));
  endtask : chk_bit

  // Register access; a timed-out wait counts as a mismatch
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        to;
    host.xfer(1'b0, a, 32'h0000_0000, q, to);
    if (to) begin
      fail("no ack on read");
      end_of_test();
    end else begin
      chk(q, exp);
    end
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        to;
    host.xfer(1'b1, a, d, q, to);
    if (to) begin
      fail("no ack on write");
      end_of_test();
    end
  endtask : wr

  // Irq is registered, so look at it mid-cycle once it has settled
  task automatic irq_is(input logic exp);
    @(negedge clk_i);
    chk_bit(irq, exp);
  endtask : irq_is

  // Raise the event of flag k for one cycle, then restore idle levels; a fault line keeps its toggled level
  task automatic fire(input int k);
    @(posedge clk_i);
    case (k)
      SIF_FLAG_BATTERY:  sense <= 1'b0;
      SIF_FLAG_SUPPLY:   d2 <= 1'b0;
      SIF_FLAG_CANFAULT: can_f <= ~can_f;
      SIF_FLAG_LINFAULT: lin_f <= ~lin_f;
      SIF_FLAG_LOCWAKE:  wake <= 1'b0;
      SIF_FLAG_WDRST:    wd_rst <= 1'b1;
      SIF_FLAG_CANWAKE:  can_wk <= 1'b1;
      default:           lin_wk <= 1'b1;
    endcase
    if (k == SIF_FLAG_WDRST) wd_off <= 1'b1;
    @(posedge clk_i);
    sense  <= 1'b1;
    d2     <= 1'b1;
    wake   <= 1'b1;
    wd_rst <= 1'b0;
    wd_off <= 1'b0;
    can_wk <= 1'b0;
    lin_wk <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : fire

  task automatic t_reset;
    rd(SIF_OFS_FLAGS, {24'h00_0000, SIF_RST_FLAGS});
    rd(SIF_OFS_MASK, 32'h0000_0000);
    irq_is(1'b0);
  endtask : t_reset

  // Each event alone sets only its own bit; rising restores set nothing
  task automatic t_each_flag;
    logic [31:0] e;
    @(posedge clk_i);
    wd_rst <= 1'b1;
    @(posedge clk_i);
    wd_rst <= 1'b0;
    rd(SIF_OFS_FLAGS, 32'h0000_0000);
    for (int k = 0; k < SIF_NFLAGS; k++) begin
      e = 32'h0000_0001 << k;
      fire(k);
      rd(SIF_OFS_FLAGS, e);
      wr(SIF_OFS_FLAGS, e);
      rd(SIF_OFS_FLAGS, 32'h0000_0000);
    end
    rd(SIF_OFS_LEVELS, {24'h00_0000, wd_off, d3, d2, d1, lin_f, can_f,
                        wake, sense});
  endtask : t_each_flag

  // Repeat events are absorbed; mask gates irq; only a one clears
  task automatic t_sticky_mask;
    fire(SIF_FLAG_CANWAKE);
    fire(SIF_FLAG_CANWAKE);
    rd(SIF_OFS_FLAGS, 32'h0000_0002);
    irq_is(1'b0);
    wr(SIF_OFS_MASK, 32'h0000_0002);
    rd(SIF_OFS_MASK, 32'h0000_0002);
    irq_is(1'b1);
    wr(SIF_OFS_FLAGS, 32'h0000_00fd);
    rd(SIF_OFS_FLAGS, 32'h0000_0002);
    wr(SIF_OFS_FLAGS, 32'h0000_0002);
    irq_is(1'b0);
    rd(SIF_OFS_FLAGS, 32'h0000_0000);
    rd(8'h0c, 32'h0000_0000);
  endtask : t_sticky_mask

  // The other two diagnosis bits each set the supply flag on clearing
  task automatic t_supply_each;
    @(posedge clk_i);
    d1 <= 1'b0;
    @(posedge clk_i);
    d1 <= 1'b1;
    rd(SIF_OFS_FLAGS, 32'h0000_0040);
    wr(SIF_OFS_FLAGS, 32'h0000_0040);
    @(posedge clk_i);
    d3 <= 1'b0;
    @(posedge clk_i);
    d3 <= 1'b1;
    rd(SIF_OFS_FLAGS, 32'h0000_0040);
    wr(SIF_OFS_FLAGS, 32'h0000_0040);
    rd(SIF_OFS_FLAGS, 32'h0000_0000);
  endtask : t_supply_each

  // A clear that meets a new event of the same flag leaves it set
  task automatic t_set_wins;
    fire(SIF_FLAG_CANWAKE);
    fork
      wr(SIF_OFS_FLAGS, 32'h0000_0002);
      begin
        @(posedge clk_i);
        can_wk <= 1'b1;
        @(posedge clk_i);
        can_wk <= 1'b0;
      end
    join
    rd(SIF_OFS_FLAGS, 32'h0000_0002);
    wr(SIF_OFS_FLAGS, 32'h0000_0002);
    rd(SIF_OFS_FLAGS, 32'h0000_0000);
  endtask : t_set_wins

  // Reset in mid-run clears flags and mask; both fault lines now sit
  // high against a low reset history and must raise no event
  task automatic t_mid_reset;
    fire(SIF_FLAG_LINWAKE);
    wr(SIF_OFS_MASK, 32'h0000_0001);
    irq_is(1'b1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SIF_OFS_FLAGS, {24'h00_0000, SIF_RST_FLAGS});
    rd(SIF_OFS_MASK, {24'h00_0000, SIF_RST_MASK});
    irq_is(1'b0);
  endtask : t_mid_reset

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // Reset two cycles, let edge history prime, then run the scenarios
  initial begin
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_each_flag();
    t_supply_each();
    t_sticky_mask();
    t_set_wins();
    t_mid_reset();
    end_of_test();
  end
endmodule : sif_irq_flags_tb
